// ==== hw/soec_top.sv ====
// Serial output-enable and input-select configuration logic
// Overview of operation
// RQ1: Eleven-bit shift register feeds eleven-bit control register
// RQ2: Mode pin high programs, low is standard
// RQ3: Each shift edge loads data, shifts stages
// RQ4: Eleven pulses fill; twelfth commits control register
// RQ5: Serial bit k enables output pair nine-minus-k
// RQ6: Bit ten selects primary or secondary input
// RQ7: Enabled pair follows clock; disabled pair tristated
// RQ8: Shift pulse with mode low resets everything
// RQ9: Only one commit accepted per reset
// RQ10: Standard mode: all enabled, data pin selects
// RQ11: Undriven pins give standard mode, primary input
// RQ12: Controller keeps shift clock under maximum rate
// RQ13: Re-enabled pair waits start-up time before active
// RQ14: Shift and commit on rising shift edge
`timescale 1ns/10ps
`include "soec_defs.svh"
module soec_top #(
  parameter int STARTUP_CYCLES = `SOEC_STARTUP_CYCLES
) (
  // Core clock and reset
  input  wire logic       CORE_CLK,
  input  wire logic       RESETN,
  // Serial configuration pins
  input  wire logic       CONFIG_SHIFT_CLOCK,
  input  wire logic       SERIAL_CONFIG_IN,
  input  wire logic       PROGRAM_ENABLE,
  // Clock inputs, sampled as levels
  input  wire logic       PRIMARY_CLOCK_INPUT,
  input  wire logic       SECONDARY_CLOCK_INPUT,
  // Output pairs, index = pair number
  output logic [9:0]      OUTPUT_PAIR_TRUE,
  output logic [9:0]      OUTPUT_PAIR_COMP,
  output logic [9:0]      OUTPUT_PAIR_OE,
  // Committed control word for observation
  output soec_pkg::soec_ctrl_s CTRL_WORD
);
  import soec_pkg::*;

  // ==========================================
  // Reset release
  logic rst_meta_reg; // First reset stage
  logic rst_n;        // Released reset
  always_ff @(posedge CORE_CLK or negedge RESETN) begin
    if (!RESETN) begin
      rst_meta_reg <= 1'b0;
      rst_n        <= 1'b0;
    end else begin
      rst_meta_reg <= 1'b1;
      rst_n        <= rst_meta_reg;
    end
  end

  // ==========================================
  // Pin synchronisers
  logic sck_s;  // Shift clock, idles high
  logic sdi_s;  // Serial data, idles low
  logic pen_s;  // Mode pin, idles low
  logic ck0_s;  // Primary clock level
  logic ck1_s;  // Secondary clock level
  soec_sync #(.RESET_VAL(1'b1)) u_sck (.clk(CORE_CLK), .rst_n(rst_n),
    .din(CONFIG_SHIFT_CLOCK), .dout(sck_s)); // see RQ11
  soec_sync #(.RESET_VAL(1'b0)) u_sdi (.clk(CORE_CLK), .rst_n(rst_n),
    .din(SERIAL_CONFIG_IN), .dout(sdi_s));
  soec_sync #(.RESET_VAL(1'b0)) u_pen (.clk(CORE_CLK), .rst_n(rst_n),
    .din(PROGRAM_ENABLE), .dout(pen_s));
  soec_sync #(.RESET_VAL(1'b0)) u_ck0 (.clk(CORE_CLK), .rst_n(rst_n),
    .din(PRIMARY_CLOCK_INPUT), .dout(ck0_s));
  soec_sync #(.RESET_VAL(1'b0)) u_ck1 (.clk(CORE_CLK), .rst_n(rst_n),
    .din(SECONDARY_CLOCK_INPUT), .dout(ck1_s));

  // ==========================================
  // Shift clock edge detection
  logic sck_prev_reg; // Previous shift clock level
  always_ff @(posedge CORE_CLK or negedge rst_n) begin
    if (!rst_n) sck_prev_reg <= 1'b1;
    else        sck_prev_reg <= sck_s;
  end
  wire sck_rise = sck_s & ~sck_prev_reg; // see RQ14

  // ==========================================
  // Sequencer state
  soec_state_e state_reg, state_next;        // Shift or done
  logic [10:0] shift_reg, shift_next;        // Serial shift stages
  soec_ctrl_s  ctrl_reg, ctrl_next;          // Committed control word
  logic [3:0]  count_reg, count_next;        // Pulses since reset

  // Serial bit k lands at shift_reg[k] after eleven pulses
  wire [10:0] shifted = {sdi_s, shift_reg[10:1]};      // see RQ3
  wire        prog_mode = pen_s;                       // see RQ2
  wire        reset_evt = sck_rise & ~prog_mode;       // see RQ8
  wire        shift_evt = sck_rise & prog_mode & (state_reg == SOEC_SHIFTING);
  wire        commit    = shift_evt & (count_reg == `SOEC_COMMIT_COUNT); // see RQ4
  wire [9:0]  reversed;                                // Pair order of bits
  genvar gi;
  generate
    for (gi = 0; gi < `SOEC_NUM_PAIRS; gi++) begin : g_rev
      assign reversed[gi] = shift_reg[9 - gi];         // see RQ5
    end
  endgenerate

  // Next-state logic
  always_comb begin
    state_next = state_reg;
    shift_next = shift_reg;
    ctrl_next  = ctrl_reg;
    count_next = count_reg;
    if (reset_evt) begin
      // Restart configuration
      state_next = SOEC_SHIFTING;                      // see RQ8
      shift_next = '0;
      ctrl_next  = soec_ctrl_s'(`SOEC_CTRL_RESET);
      count_next = '0;
    end else if (commit) begin
      // Twelfth pulse: commit, then lock
      ctrl_next.pair_enable = reversed;                // see RQ1
      ctrl_next.clk_select  = shift_reg[`SOEC_SEL_BIT];// see RQ6
      state_next = SOEC_COMMITTED;                     // see RQ9
    end else if (shift_evt) begin
      // Shift pulse
      shift_next = shifted;                            // see RQ3
      count_next = count_reg + 4'h1;
    end
  end

  // State registers
  always_ff @(posedge CORE_CLK or negedge rst_n) begin
    if (!rst_n) begin
      state_reg <= SOEC_SHIFTING;
      shift_reg <= '0;
      ctrl_reg  <= soec_ctrl_s'(`SOEC_CTRL_RESET);
      count_reg <= '0;
    end else begin
      state_reg <= state_next;
      shift_reg <= shift_next;
      ctrl_reg  <= ctrl_next;
      count_reg <= count_next;
    end
  end

  // ==========================================
  // Effective selection and enables
  wire [9:0] eff_en  = prog_mode ? ctrl_reg.pair_enable : 10'h3_FF; // see RQ10
  wire       eff_sel = prog_mode ? ctrl_reg.clk_select : sdi_s;     // see RQ10
  wire       clk_sel = eff_sel ? ck1_s : ck0_s;                     // see RQ6

  // Start-up timers for re-enabled pairs
  localparam int CW = $clog2(STARTUP_CYCLES + 1);
  logic [9:0] prev_en_reg;            // Enables in the previous cycle
  logic [9:0] active;                 // Pair is live
  always_ff @(posedge CORE_CLK or negedge rst_n) begin
    if (!rst_n) prev_en_reg <= 10'h3_FF;
    else        prev_en_reg <= eff_en;
  end
  generate
    for (gi = 0; gi < `SOEC_NUM_PAIRS; gi++) begin : g_pair
      logic [CW-1:0] wait_reg; // Cycles left before pair drives
      always_ff @(posedge CORE_CLK or negedge rst_n) begin
        if (!rst_n) wait_reg <= '0;
        else if (!eff_en[gi]) wait_reg <= '0;
        else if (!prev_en_reg[gi]) wait_reg <= CW'(STARTUP_CYCLES); // see RQ13
        else if (wait_reg != '0) wait_reg <= wait_reg - CW'(1);
      end
      assign active[gi] = eff_en[gi] & prev_en_reg[gi] & (wait_reg == '0);
    end
  endgenerate

  // ==========================================
  // Output registers
  always_ff @(posedge CORE_CLK or negedge rst_n) begin
    if (!rst_n) begin
      OUTPUT_PAIR_TRUE <= '0;
      OUTPUT_PAIR_COMP <= '0;
      OUTPUT_PAIR_OE   <= '0;
      CTRL_WORD        <= soec_ctrl_s'(`SOEC_CTRL_RESET);
    end else begin
      OUTPUT_PAIR_TRUE <= active & {10{clk_sel}};  // see RQ7
      OUTPUT_PAIR_COMP <= active & {10{~clk_sel}};
      OUTPUT_PAIR_OE   <= active;                  // see RQ7
      CTRL_WORD        <= ctrl_reg;
    end
  end

  // ==========================================
  // Assertions
  // Cycles spent in standard mode, saturating; feeds the enable check
  int std_cnt_reg;
  always_ff @(posedge CORE_CLK or negedge rst_n) begin
    if (!rst_n)                                std_cnt_reg <= 0;
    else if (prog_mode)                        std_cnt_reg <= 0;
    else if (std_cnt_reg < STARTUP_CYCLES + 3) std_cnt_reg <= std_cnt_reg + 1;
  end
  a_commit_locks: assert property (@(posedge CORE_CLK) disable iff (!rst_n) // see RQ9
    state_reg == SOEC_COMMITTED && !reset_evt |=> $stable(ctrl_reg))
    else $error("control word changed after commit");
  a_reset_clears: assert property (@(posedge CORE_CLK) disable iff (!rst_n) // see RQ8
    reset_evt |=> count_reg == 4'h0 && state_reg == SOEC_SHIFTING)
    else $error("reset pulse did not clear sequencer");
  a_commit_twelfth: assert property (@(posedge CORE_CLK) disable iff (!rst_n) // see RQ4
    $rose(state_reg == SOEC_COMMITTED) |-> $past(count_reg) == 4'hB)
    else $error("commit not on twelfth pulse");
  a_shift_data: assert property (@(posedge CORE_CLK) disable iff (!rst_n) // see RQ3
    shift_evt && !commit |=> shift_reg[10] == $past(sdi_s))
    else $error("serial data not loaded into first stage");
  a_pair_order: assert property (@(posedge CORE_CLK) disable iff (!rst_n) // see RQ5
    commit |=> ctrl_reg.pair_enable[9] == $past(shift_reg[0]))
    else $error("bit zero not mapped to pair nine");
  a_select_bit: assert property (@(posedge CORE_CLK) disable iff (!rst_n) // see RQ6
    commit |=> ctrl_reg.clk_select == $past(shift_reg[10]))
    else $error("select bit not committed");
  a_std_enable: assert property (@(posedge CORE_CLK) disable iff (!rst_n) // see RQ10
    std_cnt_reg == STARTUP_CYCLES + 3 |-> OUTPUT_PAIR_OE == 10'h3_FF)
    else $error("standard mode did not enable all pairs");
  a_disabled_tri: assert property (@(posedge CORE_CLK) disable iff (!rst_n) // see RQ7
    !eff_en[0] |=> !OUTPUT_PAIR_OE[0])
    else $error("disabled pair still driven");
  a_startup_wait: assert property (@(posedge CORE_CLK) disable iff (!rst_n) // see RQ13
    $rose(eff_en[0]) |=> !OUTPUT_PAIR_OE[0] ##1 !OUTPUT_PAIR_OE[0])
    else $error("re-enabled pair driven before start-up time");
endmodule : soec_top

// ==== pkg/soec_defs.svh ====
// Constants of the serial output-enable configuration block
`ifndef SOEC_DEFS_SVH
`define SOEC_DEFS_SVH
// ==========================================
// Widths and field positions
`define SOEC_SHIFT_W      11
`define SOEC_NUM_PAIRS    10
`define SOEC_SEL_BIT      10
`define SOEC_COMMIT_COUNT 4'hB
// ==========================================
// Reset values
`define SOEC_CTRL_RESET   11'h7FF
// ==========================================
// Timing: start-up time after re-enable, in ns
`define SOEC_STARTUP_NS     1000
`define SOEC_CLK_PERIOD_NS  8
`define SOEC_STARTUP_CYCLES ((`SOEC_STARTUP_NS + `SOEC_CLK_PERIOD_NS - 1) / `SOEC_CLK_PERIOD_NS)
`endif

// ==== pkg/soec_pkg.sv ====
// Types of the serial output-enable configuration block
package soec_pkg;
  // ==========================================
  // Configuration sequencer states
  typedef enum logic [1:0] {
    SOEC_SHIFTING  = 2'b00,
    SOEC_COMMITTED = 2'b01
  } soec_state_e;
  // ==========================================
  // Committed control word
  typedef struct packed {
    logic       clk_select;  // Input clock choice
    logic [9:0] pair_enable; // Output pair enables, index = pair number
  } soec_ctrl_s;
endpackage : soec_pkg

// ==== hw/soec_sync.sv ====
// Two-flop synchroniser for one pin level
`timescale 1ns/10ps
module soec_sync #(
  parameter logic RESET_VAL = 1'b0
) (
  // Clock and reset
  input  wire logic clk,
  input  wire logic rst_n,
  // Level in and out
  input  wire logic din,
  output logic      dout
);
  logic meta_reg; // First stage, read only by dout
  // Two flops in series
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      meta_reg <= RESET_VAL;
      dout     <= RESET_VAL;
    end else begin
      meta_reg <= din;
      dout     <= meta_reg;
    end
  end
endmodule : soec_sync

// ==== test/soec_ctrl_model.sv ====
// Model of the outside controller that drives the serial configuration pins
`timescale 1ns/10ps
module soec_ctrl_model (
  // Serial configuration pins
  output logic shift_clk,
  output logic ser_data,
  output logic prog_en
);
  // ==========================================
  // Idle levels: shift clock high, data and mode low
  initial begin
    shift_clk = 1'b1;
    ser_data  = 1'b0;
    prog_en   = 1'b0;
  end
  // One shift pulse, 64 ns period; data set while clock is low
  task automatic pulse(input logic d);
    shift_clk = 1'b0;
    ser_data  = d;
    #32;
    shift_clk = 1'b1;
    #32;
  endtask : pulse
  // Restart pulse with mode low
  task automatic restart();
    prog_en = 1'b0;
    #32;
    pulse(1'b0);
  endtask : restart
  // Eleven bits, bit 0 first, then the commit pulse
  task automatic load(input logic [10:0] w);
    prog_en = 1'b1;
    #32;
    for (int k = 0; k < 11; k++) begin
      pulse(w[k]);
    end
    pulse(1'b0);
    ser_data = 1'b0; // Released data line sits at its pull-down
  endtask : load
  // Standard mode with a chosen input select level
  task automatic std_sel(input logic s);
    prog_en  = 1'b0;
    ser_data = s;
  endtask : std_sel
endmodule : soec_ctrl_model

// ==== test/tb_soec_top.sv ====
// Self-checking bench of the serial output-enable configuration block
`timescale 1ns/10ps
`define CHK(nm, e, s) begin n_checks++; if ((s) !== (e)) begin miscompares++; \
  $display("MISMATCH %s expected %h seen %h", nm, e, s); end end
module tb_soec_top;
  import soec_pkg::*;
  // ==========================================
  // Bench signals
  logic                 core_clk, resetn, prim, sec;
  wire logic            shift_clk, ser_data, prog_en;
  logic [9:0]           true_q, comp_q, oe_q;
  soec_ctrl_s           ctrl;
  int                   miscompares = 0;
  int                   n_checks    = 0;
  logic [15:0]          lfsr_reg;
  // ==========================================
  // Design and controller model
  soec_top #(.STARTUP_CYCLES(4)) u_soec_top (
    .CORE_CLK(core_clk), .RESETN(resetn),
    .CONFIG_SHIFT_CLOCK(shift_clk), .SERIAL_CONFIG_IN(ser_data), .PROGRAM_ENABLE(prog_en),
    .PRIMARY_CLOCK_INPUT(prim), .SECONDARY_CLOCK_INPUT(sec),
    .OUTPUT_PAIR_TRUE(true_q), .OUTPUT_PAIR_COMP(comp_q), .OUTPUT_PAIR_OE(oe_q),
    .CTRL_WORD(ctrl)
  );
  soec_ctrl_model u_soec_ctrl_model (
    .shift_clk(shift_clk), .ser_data(ser_data), .prog_en(prog_en)
  );
  // ==========================================
  // Helpers
  function automatic logic [15:0] lfsr_next(input logic [15:0] v);
    return {v[14:0], v[15] ^ v[13] ^ v[12] ^ v[10]};
  endfunction : lfsr_next
  // Serial word to committed control word
  function automatic soec_ctrl_s exp_ctrl(input logic [10:0] w);
    soec_ctrl_s c;
    c.clk_select = w[10];
    for (int k = 0; k < 10; k++) begin
      c.pair_enable[9 - k] = w[k];
    end
    return c;
  endfunction : exp_ctrl
  // Settle, then compare the register and every output pair
  task automatic check_out(input soec_ctrl_s ec, input soec_ctrl_s ef);
    logic lvl;
    repeat (30) @(negedge core_clk);
    lvl = ef.clk_select ? sec : prim;
    `CHK("ctrl word", ec, ctrl)
    `CHK("pair oe", ef.pair_enable, oe_q)
    `CHK("pair true", ef.pair_enable & {10{lvl}}, true_q)
    `CHK("pair comp", ef.pair_enable & {10{~lvl}}, comp_q)
  endtask : check_out
  // Verdict and end of run
  task automatic print_verdict();
    if (miscompares == 0 && n_checks > 0) begin
      $display("== PASSED ==");
    end else begin
      $display("== FAILED ==");
    end
    $finish;
  endtask : print_verdict
  // ==========================================
  // Clock and watchdog
  initial begin
    core_clk = 1'b0;
    forever #4 core_clk = ~core_clk;
  end
  initial begin
    #100000;
    miscompares++;
    print_verdict();
  end
  // ==========================================
  // Main sequence
  initial begin
    logic [10:0] w;
    soec_ctrl_s  e;
    resetn   = 1'b0;
    prim     = 1'b1;
    sec      = 1'b0;
    lfsr_reg = 16'hFF06;
    repeat (12) @(negedge core_clk);
    resetn = 1'b1;
    repeat (8) @(negedge core_clk);
    check_out(11'h7FF, 11'h3FF);
    u_soec_ctrl_model.std_sel(1'b1);
    check_out(11'h7FF, 11'h7FF);
    for (int i = 0; i < 6; i++) begin
      lfsr_reg = lfsr_next(lfsr_reg);
      w = (i == 0) ? 11'h000 : (i == 1) ? 11'h400 : lfsr_reg[10:0];
      {prim, sec} = lfsr_reg[12:11];
      u_soec_ctrl_model.restart();
      u_soec_ctrl_model.load(w);
      check_out(exp_ctrl(w), exp_ctrl(w));
      u_soec_ctrl_model.load(~w);
      check_out(exp_ctrl(w), exp_ctrl(w));
      // Back to standard mode: pairs that w left off must wait out start-up
      e = exp_ctrl(w);
      u_soec_ctrl_model.std_sel(1'b0);
      repeat (5) @(negedge core_clk);
      `CHK("startup oe", e.pair_enable, oe_q)
    end
    u_soec_ctrl_model.restart();
    check_out(11'h7FF, 11'h3FF);
    print_verdict();
  end
endmodule : tb_soec_top
